// ### rtl/addr_rx.sv
// i2c slave address receiver with apb register access
// assumes SCL is a clock port from the bus master; core registers on CORE_CLK
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module addr_rx
   import addr_rx_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic SCL_CLK,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   output logic SCL_OUT,
   output logic SCL_OE,
   output logic IRQ,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);
   import addr_rx_pkg::*;

   // core-domain registers
   logic [7:0] control_q;
   logic [7:0] own_address_q;
   logic [7:0] rx_holding_buffer_q;
   logic buffer_full_flag_q;
   logic receive_overflow_flag_q;
   logic serial_port_irq_flag_q;
   logic address_update_flag_q;
   logic rw_bit_q;
   logic tenbit_second_q;
   logic hold_scl_q;

   // link-domain state
   link_state_t link_state_q;
   logic [7:0] rx_shift_reg_q;
   logic [3:0] bit_count_q;
   logic ack_q;
   logic byte_toggle_q;
   logic [7:0] byte_hold_q;

   // start detection and link reset
   logic start_toggle_q;
   logic link_rst_n;

   logic byte_sync;
   logic byte_sync_seen_q;
   // last start event already taken by the shifter
   logic start_taken_q;
   logic ack_allow_q;
   logic irq_pending_q;

   function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] idx);
      reg_hit = (addr[31:2] == {22'h000000, idx}) && (addr[1:0] == 2'h0);
   endfunction

   assign link_rst_n = RSTN & control_q[CTRL_ENABLE_BIT];

   // start: SDA falls while SCL high; toggled on SDA edge, crosses as an event
   always_ff @(negedge SDA_IN or negedge link_rst_n) begin
      if (!link_rst_n) begin
         start_toggle_q <= 1'b0;
      end else if (SCL_CLK) begin
         start_toggle_q <= ~start_toggle_q;
      end
   end

   // shift on rising SCL; a new start resets the bit counter
   always_ff @(posedge SCL_CLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_state_q <= LK_IDLE;
         rx_shift_reg_q <= 8'h00;
         bit_count_q <= 4'h0;
         start_taken_q <= 1'b0;
      end else begin
         case (link_state_q)
            LK_IDLE: begin
               if (start_toggle_q != start_taken_q) begin
                  link_state_q <= LK_SHIFT;
                  start_taken_q <= start_toggle_q;
                  rx_shift_reg_q <= {7'h00, SDA_IN};
                  bit_count_q <= 4'h1;
               end
            end
            LK_SHIFT: begin
               if (start_toggle_q != start_taken_q) begin
                  start_taken_q <= start_toggle_q;
                  rx_shift_reg_q <= {7'h00, SDA_IN};
                  bit_count_q <= 4'h1;
               end else begin
                  rx_shift_reg_q <= {rx_shift_reg_q[6:0], SDA_IN};
                  bit_count_q <= bit_count_q + 4'h1;
                  if (bit_count_q == BITS_PER_BYTE - 4'h1) begin
                     link_state_q <= LK_ACK;
                  end
               end
            end
            LK_ACK: begin
               // the ninth rising edge carries the ack bit, not data
               link_state_q <= LK_SHIFT;
               bit_count_q <= 4'h0;
            end
            default: link_state_q <= LK_IDLE;
         endcase
      end
   end

   // eighth falling edge: decide ack from the core's ack permission
   logic ack_allow_meta_q;
   logic ack_allow_link_q;
   always_ff @(posedge SCL_CLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ack_allow_meta_q <= 1'b0;
         ack_allow_link_q <= 1'b0;
      end else begin
         ack_allow_meta_q <= ack_allow_q;
         ack_allow_link_q <= ack_allow_meta_q;
      end
   end

   always_ff @(negedge SCL_CLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ack_q <= 1'b0;
         byte_toggle_q <= 1'b0;
         byte_hold_q <= 8'h00;
      end else if (link_state_q == LK_ACK && !ack_q) begin
         // the compare inputs freeze here for the core
         byte_hold_q <= rx_shift_reg_q;
         byte_toggle_q <= ~byte_toggle_q;
         // ack only when the core saw no full buffer or overflow
         ack_q <= ack_allow_link_q &&
                  (rx_shift_reg_q[7:1] == own_address_q[7:1] ||
                   (control_q[CTRL_TENBIT_BIT] &&
                    rx_shift_reg_q[7:3] == TENBIT_PREFIX));
      end else begin
         ack_q <= 1'b0; // ninth falling edge ends the ack
      end
   end

   // core: sync link events
   bit_sync u_byte_sync (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .din(byte_toggle_q),
      .dout(byte_sync)
   );

   logic pulse_byte;
   assign pulse_byte = byte_sync ^ byte_sync_seen_q;

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         byte_sync_seen_q <= 1'b0;
      end else begin
         byte_sync_seen_q <= byte_sync;
      end
   end

   // apb decode
   logic apb_access;
   logic apb_wr;
   logic apb_rd;
   assign apb_access = PSEL && PENABLE && PREADY;
   assign apb_wr = apb_access && PWRITE;
   assign apb_rd = apb_access && !PWRITE;

   logic mapped;
   assign mapped = reg_hit(PADDR, RX_HOLDING_BUFFER_IDX) ||
                   reg_hit(PADDR, SERIAL_PORT_CONTROL_IDX) ||
                   reg_hit(PADDR, SERIAL_PORT_STATUS_IDX) ||
                   reg_hit(PADDR, OWN_ADDRESS_IDX) ||
                   reg_hit(PADDR, IRQ_FLAG_IDX);

   logic byte_match;
   logic is_tenbit_high;
   assign is_tenbit_high = control_q[CTRL_TENBIT_BIT] && byte_hold_q[7:3] == TENBIT_PREFIX;
   assign byte_match = (byte_hold_q[7:1] == own_address_q[7:1]) || is_tenbit_high;

   // flag and buffer updates; hardware set wins over software clear
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_holding_buffer_q <= 8'h00;
         buffer_full_flag_q <= 1'b0;
         receive_overflow_flag_q <= 1'b0;
         serial_port_irq_flag_q <= 1'b0;
         rw_bit_q <= 1'b0;
      end else begin
         if (apb_rd && reg_hit(PADDR, RX_HOLDING_BUFFER_IDX)) begin
            buffer_full_flag_q <= 1'b0;
         end
         if (apb_wr && reg_hit(PADDR, IRQ_FLAG_IDX) && !PWDATA[0]) begin
            serial_port_irq_flag_q <= 1'b0;
         end
         if (apb_wr && reg_hit(PADDR, SERIAL_PORT_STATUS_IDX) && !PWDATA[STAT_OV_BIT]) begin
            receive_overflow_flag_q <= 1'b0;
         end
         if (pulse_byte) begin
            serial_port_irq_flag_q <= 1'b1;
            if (!buffer_full_flag_q && !receive_overflow_flag_q && byte_match) begin
               rx_holding_buffer_q <= byte_hold_q;
               buffer_full_flag_q <= 1'b1;
               rw_bit_q <= byte_hold_q[0];
            end else if (byte_match) begin
               receive_overflow_flag_q <= 1'b1;
            end
         end
      end
   end

   // ten-bit sequencing: update flag and SCL hold
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         address_update_flag_q <= 1'b0;
         tenbit_second_q <= 1'b0;
         hold_scl_q <= 1'b0;
      end else if (pulse_byte && control_q[CTRL_TENBIT_BIT] && byte_match &&
                   !buffer_full_flag_q && !receive_overflow_flag_q &&
                   !(is_tenbit_high && byte_hold_q[0])) begin
         address_update_flag_q <= 1'b1;
         hold_scl_q <= 1'b1;
         tenbit_second_q <= is_tenbit_high;
      end else if (apb_wr && reg_hit(PADDR, OWN_ADDRESS_IDX)) begin
         address_update_flag_q <= 1'b0;
         hold_scl_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         control_q <= CONTROL_RESET;
         own_address_q <= OWN_ADDRESS_RESET;
      end else if (apb_wr) begin
         if (reg_hit(PADDR, SERIAL_PORT_CONTROL_IDX)) begin
            control_q <= PWDATA[7:0];
         end
         if (reg_hit(PADDR, OWN_ADDRESS_IDX)) begin
            own_address_q <= PWDATA[7:0];
         end
      end
   end

   // permission to ack, sent to the link as a level
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ack_allow_q <= 1'b0;
      end else begin
         ack_allow_q <= !buffer_full_flag_q && !receive_overflow_flag_q;
      end
   end

   // apb response; always ready in one access cycle
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !mapped;
         PRDATA <= 32'h00000000;
         if (PSEL && !PENABLE && !PWRITE) begin
            if (reg_hit(PADDR, RX_HOLDING_BUFFER_IDX)) begin
               PRDATA <= {24'h000000, rx_holding_buffer_q};
            end else if (reg_hit(PADDR, SERIAL_PORT_CONTROL_IDX)) begin
               PRDATA <= {24'h000000, control_q};
            end else if (reg_hit(PADDR, OWN_ADDRESS_IDX)) begin
               PRDATA <= {24'h000000, own_address_q};
            end else if (reg_hit(PADDR, IRQ_FLAG_IDX)) begin
               PRDATA <= {31'h00000000, serial_port_irq_flag_q};
            end else if (reg_hit(PADDR, SERIAL_PORT_STATUS_IDX)) begin
               PRDATA <= {24'h000000, 1'b0, receive_overflow_flag_q, 3'h0, rw_bit_q,
                          address_update_flag_q, buffer_full_flag_q};
            end
         end
      end
   end

   // pins come from flip-flops; sda low during ack, scl held while update pending
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         SDA_OUT <= 1'b0;
         SDA_OE <= 1'b0;
         SCL_OUT <= 1'b0;
         SCL_OE <= 1'b0;
         IRQ <= 1'b0;
         irq_pending_q <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
         SDA_OE <= ack_q;
         SCL_OUT <= 1'b0;
         SCL_OE <= hold_scl_q;
         irq_pending_q <= serial_port_irq_flag_q;
         IRQ <= serial_port_irq_flag_q && control_q[CTRL_IRQ_EN_BIT];
      end
   end

   // assertions
   buf_load_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      pulse_byte && byte_match && !buffer_full_flag_q && !receive_overflow_flag_q
      |=> buffer_full_flag_q && rx_holding_buffer_q == $past(byte_hold_q))
      else $error("matched byte not loaded");
   no_load_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      pulse_byte && buffer_full_flag_q |=> $stable(rx_holding_buffer_q))
      else $error("buffer overwritten while full");
   irq_set_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      pulse_byte |=> serial_port_irq_flag_q)
      else $error("irq flag not set on byte");
   irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      IRQ |-> $past(serial_port_irq_flag_q) && $past(control_q[CTRL_IRQ_EN_BIT]))
      else $error("interrupt raised while disabled");
   bf_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      apb_rd && reg_hit(PADDR, RX_HOLDING_BUFFER_IDX) && !pulse_byte
      |=> !buffer_full_flag_q)
      else $error("buffer read did not clear full flag");
   ua_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      apb_wr && reg_hit(PADDR, OWN_ADDRESS_IDX) && !pulse_byte
      |=> !address_update_flag_q ##1 !SCL_OE)
      else $error("address write did not release scl");
   ua_set_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      pulse_byte && is_tenbit_high && !byte_hold_q[0] && !buffer_full_flag_q &&
      !receive_overflow_flag_q |=> address_update_flag_q ##1 SCL_OE)
      else $error("ten-bit high byte did not hold scl");
   ack_drive_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      SDA_OE |-> !SDA_OUT)
      else $error("ack drives sda high");
endmodule

// ### rtl/addr_rx_pkg.sv
// package: register map, field positions and reset values of the i2c address receiver
// assumes an apb slave with 32-bit data; printed offsets are indices, byte address = 4 * index
package addr_rx_pkg;
   localparam logic [7:0] RX_HOLDING_BUFFER_IDX = 8'h13;
   localparam logic [7:0] SERIAL_PORT_CONTROL_IDX = 8'h14;
   localparam logic [7:0] SERIAL_PORT_STATUS_IDX = 8'h15;
   localparam logic [7:0] OWN_ADDRESS_IDX = 8'h16;
   localparam logic [7:0] IRQ_FLAG_IDX = 8'h17;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] OWN_ADDRESS_RESET = 8'h00;
   localparam int CTRL_ENABLE_BIT = 5;
   localparam int CTRL_TENBIT_BIT = 3;
   localparam int CTRL_IRQ_EN_BIT = 0;
   localparam int STAT_BF_BIT = 0;
   localparam int STAT_UA_BIT = 1;
   localparam int STAT_RW_BIT = 2;
   localparam int STAT_OV_BIT = 6;
   localparam logic [4:0] TENBIT_PREFIX = 5'h1E;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [1:0] {LK_IDLE, LK_SHIFT, LK_ACK} link_state_t;
endpackage

// ### rtl/bit_sync.sv
// two-flop synchroniser for one level
// assumes the input is asynchronous to clk
`timescale 1ns/10ps
module bit_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ### verification/i2c_master_model.sv
// behavioural i2c bus master that sends address bytes to the receiver
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/10ps
module i2c_master_model (
   input wire logic scl,
   input wire logic sda,
   output logic scl_drv,
   output logic sda_drv,
   output logic err
);
   localparam int HALF = 16;
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
      err = 1'b0;
   end
   // waits out clock stretching, but gives up and flags it after a bound
   task automatic rise(output logic s);
      int n;
      n = 0;
      scl_drv = 1'b1;
      while (scl !== 1'b1 && n < 20000) begin
         #1;
         n++;
      end
      if (n >= 20000) err = 1'b1;
      s = sda;
      #HALF;
   endtask
   // also serves as a repeated start when entered with the clock low
   task automatic start_cond();
      logic s;
      sda_drv = 1'b1;
      #HALF;
      rise(s);
      sda_drv = 1'b0;
      #HALF;
      scl_drv = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         sda_drv = b[i];
         #HALF;
         rise(s);
         scl_drv = 1'b0;
      end
      sda_drv = 1'b1;
      // long low phase lets the core-side ack decision reach the pin
      #200;
      rise(s);
      ack = ~s;
      scl_drv = 1'b0;
      #HALF;
   endtask
   task automatic stop_cond();
      logic s;
      sda_drv = 1'b0;
      #HALF;
      rise(s);
      sda_drv = 1'b1;
      #HALF;
   endtask
endmodule

// ### verification/test_i2c_slave_address_receive.sv
// self-checking bench: apb register tasks plus an i2c master model on the bus side
// assumes one-cycle apb answers and byte address equal to four times the register index
`timescale 1ns/10ps
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module test_i2c_slave_address_receive;
   import addr_rx_pkg::*;
   logic core_clk, rstn, psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata, d;
   logic pready, pslverr, sda_out, sda_oe, scl_out, scl_oe, irq, e, a;
   logic scl_drv, sda_drv, merr;
   wire scl_line = (scl_oe ? scl_out : 1'b1) & scl_drv;
   wire sda_line = (sda_oe ? sda_out : 1'b1) & sda_drv;
   int fails = 0;
   int n_checks = 0;
   addr_rx u_dut (.CORE_CLK(core_clk), .RSTN(rstn), .SCL_CLK(scl_line), .SDA_IN(sda_line),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .IRQ(irq),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   i2c_master_model u_mst (.scl(scl_line), .sda(sda_line), .scl_drv(scl_drv),
      .sda_drv(sda_drv), .err(merr));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
         output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b1, idx, {24'h0, v}, d, e);
   endtask
   task automatic rd(input logic [7:0] idx);
      apb(1'b0, idx, 32'h0, d, e);
   endtask
   // polls status until the address update flag sets; bounded
   task automatic wait_ua();
      int n;
      n = 0;
      do begin
         rd(SERIAL_PORT_STATUS_IDX);
         n++;
      end while (d[STAT_UA_BIT] !== 1'b1 && n < 200);
      if (n >= 200) begin
         fails++;
         wrap_up();
      end
   endtask
   task automatic send(input logic [7:0] b, input logic ex_ack, input logic stop);
      u_mst.start_cond();
      u_mst.send_byte(b, a);
      `CHK("ack", ex_ack, a);
      if (stop) u_mst.stop_cond();
   endtask
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      fails++;
      wrap_up();
   end
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      rd(SERIAL_PORT_CONTROL_IDX);
      `CHK("control reset", CONTROL_RESET, d);
      rd(OWN_ADDRESS_IDX);
      `CHK("own address reset", OWN_ADDRESS_RESET, d);
      apb(1'b0, 8'h10, 32'h0, d, e);
      `CHK("unmapped error", 1'b1, e);
      $display("test registers done");
      wr(OWN_ADDRESS_IDX, 8'hA4);
      wr(SERIAL_PORT_CONTROL_IDX, 8'h21);
      send(8'hA5, 1'b1, 1'b1);
      rd(SERIAL_PORT_STATUS_IDX);
      `CHK("buffer full", 1'b1, d[STAT_BF_BIT]);
      rd(IRQ_FLAG_IDX);
      `CHK("irq flag", 1'b1, d[0]);
      `CHK("irq pin", 1'b1, irq);
      wr(IRQ_FLAG_IDX, 8'h00);
      repeat (2) @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq);
      wr(SERIAL_PORT_CONTROL_IDX, 8'h20);
      send(8'hA4, 1'b0, 1'b1);
      rd(IRQ_FLAG_IDX);
      `CHK("irq flag refused", 1'b1, d[0]);
      `CHK("irq masked", 1'b0, irq);
      rd(RX_HOLDING_BUFFER_IDX);
      `CHK("buffer kept", 8'hA5, d[7:0]);
      rd(SERIAL_PORT_STATUS_IDX);
      `CHK("full cleared", 1'b0, d[STAT_BF_BIT]);
      `CHK("overflow", 1'b1, d[STAT_OV_BIT]);
      send(8'hA4, 1'b0, 1'b1);
      wr(SERIAL_PORT_STATUS_IDX, 8'h00);
      send(8'h52, 1'b0, 1'b1);
      rd(SERIAL_PORT_STATUS_IDX);
      `CHK("no load on miss", 1'b0, d[STAT_BF_BIT]);
      wr(IRQ_FLAG_IDX, 8'h00);
      $display("test seven bit done");
      wr(SERIAL_PORT_CONTROL_IDX, 8'h29);
      wr(OWN_ADDRESS_IDX, 8'hF2);
      // the master stalls on the stretched clock while software answers
      fork
         send(8'hF2, 1'b1, 1'b0);
         begin
            wait_ua();
            `CHK("high byte flags", 3'b011, d[2:0]);
            `CHK("stretch", 1'b1, scl_oe);
            wr(OWN_ADDRESS_IDX, 8'h5A);
         end
      join
      rd(SERIAL_PORT_STATUS_IDX);
      `CHK("update cleared", 1'b0, d[STAT_UA_BIT]);
      `CHK("released", 1'b0, scl_oe);
      rd(RX_HOLDING_BUFFER_IDX);
      `CHK("high byte", 8'hF2, d[7:0]);
      wr(IRQ_FLAG_IDX, 8'h00);
      fork
         begin
            u_mst.send_byte(8'h5A, a);
            `CHK("low ack", 1'b1, a);
         end
         begin
            wait_ua();
            `CHK("low byte flags", 2'b11, d[1:0]);
            wr(OWN_ADDRESS_IDX, 8'hF2);
         end
      join
      rd(SERIAL_PORT_STATUS_IDX);
      `CHK("restore clears", 1'b0, d[STAT_UA_BIT]);
      rd(RX_HOLDING_BUFFER_IDX);
      `CHK("low byte", 8'h5A, d[7:0]);
      wr(IRQ_FLAG_IDX, 8'h00);
      send(8'hF3, 1'b1, 1'b0);
      rd(IRQ_FLAG_IDX);
      `CHK("repeat irq", 1'b1, d[0]);
      rd(SERIAL_PORT_STATUS_IDX);
      `CHK("repeat full", 1'b1, d[STAT_BF_BIT]);
      `CHK("read direction", 1'b1, d[STAT_RW_BIT]);
      rd(RX_HOLDING_BUFFER_IDX);
      wr(IRQ_FLAG_IDX, 8'h00);
      wr(OWN_ADDRESS_IDX, 8'hF2);
      u_mst.stop_cond();
      `CHK("bus stalls", 1'b0, merr);
      $display("test ten bit done");
      wrap_up();
   end
endmodule
